//--- irq_edge_pkg.sv
/*
  Constants for the interrupt edge and enable control block: register
  indices and byte addresses, field positions, reset values.
  Assumes a 32-bit APB master placing each register in one aligned word.
*/
// Operation
// [RQ1] pin 4 edge: 0 rising, 1 falling
// [RQ2] gate bit 1 blocks pin 4/3 flag
// [RQ3] pin 3 edge: 0 rising, 1 falling
// [RQ4] low edge register: pins 2..0, top zero
// [RQ5] serial1, serial0, timer3, timer2 enables
// [RQ6] timer1, timer0, pin4, pin3 enables
// [RQ7] pins 2, 1, 0 and chip-enable enables
// [RQ8] serial 1 pending in bit 0 only
// [RQ9] power-on and watchdog reset clear; others retain
// [RQ10] request only when pending and enabled
package irq_edge_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_EDGE_HIGH = 8'h1E;
  localparam logic [7:0] IDX_EDGE_LOW = 8'h1F;
  localparam logic [7:0] IDX_EN_SERIAL_TIMER = 8'h2D;
  localparam logic [7:0] IDX_EN_TIMER_PINS = 8'h2E;
  localparam logic [7:0] IDX_EN_PINS_CHIPEN = 8'h2F;
  localparam logic [7:0] IDX_SERIAL1_REQ = 8'h34;
  localparam int ADDR_MIN_W = 8;
  // ==========================================================
  // field positions
  localparam int EXT4_EDGE_SEL_BIT = 3;
  localparam int EXT4_FLAG_GATE_BIT = 2;
  localparam int EXT3_EDGE_SEL_BIT = 1;
  localparam int EXT3_FLAG_GATE_BIT = 0;
  localparam int SERIAL1_PENDING_BIT = 0;
  // bit order of request and enable vectors
  localparam int SRC_CHIPEN = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_EXT3 = 4;
  localparam int SRC_EXT4 = 5;
  localparam int SRC_SERIAL1 = 11;
  localparam int NUM_SRC = 12;
  localparam int NUM_EXT = 5;
  // ==========================================================
  // reset values
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

//--- irq_edge_ctrl.sv
/*
  Interrupt edge select, enable and serial 1 request registers with
  external pin edge detection and gated request output, APB slave.
  Assumes pins synchronous to clk_in; the core clears pin flags by
  pulses on ext_flag_clear_in; watchdog/stack reset arrives as a pulse.
*/
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module irq_edge_ctrl
  import irq_edge_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wdt_reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic ext_irq_pin0_in,
  input wire logic ext_irq_pin1_in,
  input wire logic ext_irq_pin2_in,
  input wire logic ext_irq_pin3_in,
  input wire logic ext_irq_pin4_in,
  input wire logic [NUM_EXT-1:0] ext_flag_clear_in,
  input wire logic serial1_event_in,
  input wire logic serial0_pending_in,
  input wire logic [3:0] timer_pending_in,
  input wire logic chipen_pending_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [NUM_EXT-1:0] ext_pending_out,
  output logic [NUM_SRC-1:0] irq_request_out
);
  // ==========================================================
  // elaboration check
  if (ADDR_W < ADDR_MIN_W) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // ==========================================================
  // storage
  logic [3:0] edge_select_high;
  logic [2:0] edge_select_low;
  logic [3:0] irq_enable_serial_timer;
  logic [3:0] irq_enable_timer_pins;
  logic [3:0] irq_enable_pins_chipen;
  logic serial1_irq_pending;
  logic [NUM_EXT-1:0] ext_pend;
  logic [NUM_EXT-1:0] pin_prev;
  logic clear_all;

  // power-on or watchdog/stack reset clears; chip-enable reset does not
  assign clear_all = !resetn_in || wdt_reset_in; // [RQ9]

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  wire sel_edge_high = hit(paddr_in, IDX_EDGE_HIGH);
  wire sel_edge_low = hit(paddr_in, IDX_EDGE_LOW);
  wire sel_en_st = hit(paddr_in, IDX_EN_SERIAL_TIMER);
  wire sel_en_tp = hit(paddr_in, IDX_EN_TIMER_PINS);
  wire sel_en_pc = hit(paddr_in, IDX_EN_PINS_CHIPEN);
  wire sel_s1 = hit(paddr_in, IDX_SERIAL1_REQ);
  wire mapped = sel_edge_high || sel_edge_low || sel_en_st ||
                sel_en_tp || sel_en_pc || sel_s1;
  wire access = psel_in && penable_in;
  // transfer completes on the edge where registered pready is high
  wire done = access && pready_out;
  wire wr_ok = done && pwrite_in && pstrb_in[0] && mapped;

  // read mux; unused upper bits read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = READ_ZERO;
    if (sel_edge_high) begin
      rd_mux[3:0] = edge_select_high;
    end else if (sel_edge_low) begin
      rd_mux[2:0] = edge_select_low; // [RQ4]
    end else if (sel_en_st) begin
      rd_mux[3:0] = irq_enable_serial_timer;
    end else if (sel_en_tp) begin
      rd_mux[3:0] = irq_enable_timer_pins;
    end else if (sel_en_pc) begin
      rd_mux[3:0] = irq_enable_pins_chipen;
    end else if (sel_s1) begin
      rd_mux[SERIAL1_PENDING_BIT] = serial1_irq_pending; // [RQ8]
    end
  end

  // ==========================================================
  // apb answer: one wait state, registered ready and data
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      prdata_out <= READ_ZERO;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= access && !pready_out;
      prdata_out <= (access && !pwrite_in) ? rd_mux : READ_ZERO;
      pslverr_out <= access && !pready_out && !mapped;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_in) begin
    if (clear_all) begin // [RQ9]
      edge_select_high <= RESET_NIBBLE;
      edge_select_low <= RESET_NIBBLE[2:0];
      irq_enable_serial_timer <= RESET_NIBBLE;
      irq_enable_timer_pins <= RESET_NIBBLE;
      irq_enable_pins_chipen <= RESET_NIBBLE;
    end else if (wr_ok) begin
      if (sel_edge_high) edge_select_high <= pwdata_in[3:0];
      if (sel_edge_low) edge_select_low <= pwdata_in[2:0]; // [RQ4]
      if (sel_en_st) irq_enable_serial_timer <= pwdata_in[3:0]; // [RQ5]
      if (sel_en_tp) irq_enable_timer_pins <= pwdata_in[3:0]; // [RQ6]
      if (sel_en_pc) irq_enable_pins_chipen <= pwdata_in[3:0]; // [RQ7]
    end
  end

  // ==========================================================
  // serial 1 pending flag: event wins over a software write
  wire s1_wr = wr_ok && sel_s1;
  wire next_s1 = serial1_event_in ||
                 (s1_wr ? pwdata_in[SERIAL1_PENDING_BIT]
                        : serial1_irq_pending);
  always_ff @(posedge clk_in) begin
    if (clear_all) begin
      serial1_irq_pending <= 1'b0;
    end else begin
      serial1_irq_pending <= next_s1; // [RQ8]
    end
  end

  // ==========================================================
  // external pin edge detection
  wire [NUM_EXT-1:0] pins = {ext_irq_pin4_in, ext_irq_pin3_in,
                             ext_irq_pin2_in, ext_irq_pin1_in,
                             ext_irq_pin0_in};
  // per-pin edge select: 0 rising, 1 falling
  wire [NUM_EXT-1:0] ext_edge_sel = {
    edge_select_high[EXT4_EDGE_SEL_BIT], // [RQ1]
    edge_select_high[EXT3_EDGE_SEL_BIT], // [RQ3]
    edge_select_low};                    // [RQ4]
  // gate bit 1 blocks flag setting on the shared pins
  wire [NUM_EXT-1:0] ext_flag_gate = {
    edge_select_high[EXT4_FLAG_GATE_BIT],
    edge_select_high[EXT3_FLAG_GATE_BIT], 3'b000}; // [RQ2]
  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_EXT-1:0] next_pend;

  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
    wire rise = pins[i] && !pin_prev[i];
    wire fall = !pins[i] && pin_prev[i];
    assign ext_hit[i] = (ext_edge_sel[i] ? fall : rise) &&
                        !ext_flag_gate[i]; // [RQ1] [RQ2] [RQ3]
    // a detected edge wins over a clear in the same cycle
    assign next_pend[i] = ext_hit[i] ||
                          (ext_pend[i] && !ext_flag_clear_in[i]);
  end

  // pin history is loaded from the pins during reset to avoid false edges
  always_ff @(posedge clk_in) begin
    if (clear_all) begin
      pin_prev <= pins;
      ext_pend <= '0;
    end else begin
      pin_prev <= pins;
      ext_pend <= next_pend;
    end
  end

  // ==========================================================
  // gated request to the core
  wire [NUM_SRC-1:0] pend_vec = {serial1_irq_pending, serial0_pending_in,
                                 timer_pending_in, ext_pend,
                                 chipen_pending_in};
  wire [NUM_SRC-1:0] en_vec = {irq_enable_serial_timer,
                               irq_enable_timer_pins,
                               irq_enable_pins_chipen};
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_request_out <= '0;
      ext_pending_out <= '0;
    end else begin
      irq_request_out <= pend_vec & en_vec; // [RQ10]
      ext_pending_out <= next_pend & {NUM_EXT{!wdt_reset_in}};
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_edge4;
    !wdt_reset_in && !edge_select_high[EXT4_EDGE_SEL_BIT] &&
    !edge_select_high[EXT4_FLAG_GATE_BIT] && ext_irq_pin4_in &&
    !pin_prev[4] |=> ext_pend[4];
  endproperty
  a_edge4: assert property (p_edge4) else $error("pin4 edge lost"); // [RQ1]

  property p_gate;
    $rose(ext_pend[4]) |-> !$past(edge_select_high[EXT4_FLAG_GATE_BIT]);
  endproperty
  a_gate: assert property (p_gate) else $error("pin4 gate ignored"); // [RQ2]

  property p_edge3_fall;
    !wdt_reset_in && edge_select_high[EXT3_EDGE_SEL_BIT] &&
    !edge_select_high[EXT3_FLAG_GATE_BIT] && !ext_irq_pin3_in &&
    pin_prev[3] |=> ext_pend[3];
  endproperty
  a_edge3_fall: assert property (p_edge3_fall) // [RQ3]
    else $error("pin3 falling edge lost");

  property p_low_top;
    done && !pwrite_in && sel_edge_low |-> prdata_out[31:3] == '0;
  endproperty
  a_low_top: assert property (p_low_top) // [RQ4]
    else $error("edge low upper bits set");

  property p_en_write;
    wr_ok && sel_en_st && !wdt_reset_in |=>
      irq_enable_serial_timer == $past(pwdata_in[3:0]);
  endproperty
  a_en_write: assert property (p_en_write) // [RQ5]
    else $error("enable write lost");

  property p_s1_read;
    done && !pwrite_in && sel_s1 |->
      prdata_out == {31'h0000_0000, $past(serial1_irq_pending)};
  endproperty
  a_s1_read: assert property (p_s1_read) // [RQ8]
    else $error("serial1 read wrong");

  property p_wdt_clear;
    wdt_reset_in |=> irq_enable_timer_pins == 4'h0 &&
      edge_select_high == 4'h0 && !serial1_irq_pending;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) // [RQ9]
    else $error("watchdog reset did not clear");

  property p_request;
    ##1 irq_request_out == $past(pend_vec & en_vec);
  endproperty
  a_request: assert property (p_request) // [RQ10]
    else $error("request not gated");

  property p_ready;
    access && !pready_out |=> pready_out ##1 !pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("apb ready timing");

  // pin 0: a selected falling edge sets the flag
  property p_edge0_fall;
    !wdt_reset_in && edge_select_low[0] && !ext_irq_pin0_in &&
    pin_prev[0] |=> ext_pend[0];
  endproperty
  a_edge0_fall: assert property (p_edge0_fall) // [RQ4]
    else $error("pin0 falling edge lost");

  property p_gate3;
    $rose(ext_pend[3]) |-> !$past(edge_select_high[EXT3_FLAG_GATE_BIT]);
  endproperty
  a_gate3: assert property (p_gate3) // [RQ2]
    else $error("pin3 gate ignored");

  property p_en_tp_write;
    wr_ok && sel_en_tp && !wdt_reset_in |=>
      irq_enable_timer_pins == $past(pwdata_in[3:0]);
  endproperty
  a_en_tp_write: assert property (p_en_tp_write) // [RQ6]
    else $error("timer and pin enable write lost");

  property p_en_pc_write;
    wr_ok && sel_en_pc && !wdt_reset_in |=>
      irq_enable_pins_chipen == $past(pwdata_in[3:0]);
  endproperty
  a_en_pc_write: assert property (p_en_pc_write) // [RQ7]
    else $error("pin and chip-enable enable write lost");

  // a serial 1 event sets the flag even against a software clear
  property p_s1_event;
    serial1_event_in && !wdt_reset_in |=> serial1_irq_pending;
  endproperty
  a_s1_event: assert property (p_s1_event) // [RQ8]
    else $error("serial1 event lost");

  c_edge4: cover property (ext_hit[4]);
  c_wdt: cover property (wdt_reset_in);
  c_gated: cover property (ext_flag_gate[3] && ext_edge_sel[3] == 1'b0 &&
                           pins[3] && !pin_prev[3]);
  c_s1_req: cover property (irq_request_out[SRC_SERIAL1]);
  c_err: cover property (pslverr_out && pready_out);
endmodule

//--- irq_source_model.sv
/*
  Far-side sources: five external interrupt pins and the serial 1 event.
  Assumes the bench commands levels; outputs change only at clock edges.
*/
`timescale 1ns/10ps
module irq_source_model (
  input wire logic clk_in,
  input wire logic [4:0] level_in,
  input wire logic fire_in,
  output logic [4:0] pin_out,
  output logic serial1_event_out
);
  // ==========================================================
  // pins synchronous to the clock, event a copy of fire_in one cycle later
  always_ff @(posedge clk_in) begin
    pin_out <= level_in;
    serial1_event_out <= fire_in;
  end
endmodule

//--- interrupt_edge_enable_ctrl_tb_top.sv
/*
  Bench for irq_edge_ctrl: register table, pin edges, enables, resets.
  Assumes irq_source_model drives the pins and the serial 1 event.
*/
`timescale 1ns/10ps
module interrupt_edge_enable_ctrl_tb_top;
  // ==========================================================
  // signals
  logic clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic wdt = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [4:0] lv = 5'h00;
  logic [4:0] clr = 5'h00;
  logic fire = 1'h0;
  logic s0 = 1'h0;
  logic chipen = 1'h0;
  logic [3:0] tmr = 4'h0;
  logic [4:0] pins_w;
  logic ev;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pend;
  logic [11:0] irq;
  int mismatches = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] a; logic [31:0] q; logic e;} row_s;
  // address, value read back after writing 0xF, error
  row_s rows [7] = '{'{8'h78, 32'hF, 1'h0}, '{8'h7C, 32'h7, 1'h0},
    '{8'hB4, 32'hF, 1'h0}, '{8'hB8, 32'hF, 1'h0},
    '{8'hBC, 32'hF, 1'h0}, '{8'hD0, 32'h1, 1'h0},
    '{8'h80, 32'h0, 1'h1}};

  // ==========================================================
  // instances
  irq_source_model i_irq_source_model (.clk_in(clk_in), .level_in(lv),
    .fire_in(fire), .pin_out(pins_w), .serial1_event_out(ev));
  irq_edge_ctrl i_irq_edge_ctrl (.clk_in(clk_in), .resetn_in(resetn_in),
    .wdt_reset_in(wdt), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .ext_irq_pin0_in(pins_w[0]),
    .ext_irq_pin1_in(pins_w[1]), .ext_irq_pin2_in(pins_w[2]),
    .ext_irq_pin3_in(pins_w[3]), .ext_irq_pin4_in(pins_w[4]),
    .ext_flag_clear_in(clr), .serial1_event_in(ev),
    .serial0_pending_in(s0), .timer_pending_in(tmr),
    .chipen_pending_in(chipen), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .ext_pending_out(pend), .irq_request_out(irq));

  // ==========================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  // setup, access held until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic pins(input logic [4:0] v);
    lv <= v;
    repeat (4) @(posedge clk_in);
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #50000;
    mismatches++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'h1;
    @(posedge clk_in);
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].a, 32'h0, rows[i].e);
      wr(rows[i].a, 32'hF);
      rd(rows[i].a, rows[i].q, rows[i].e);
    end
    pstrb <= 4'hE;
    wr(8'hB8, 32'h0);
    pstrb <= 4'hF;
    rd(8'hB8, 32'hF, 1'h0);
    s0 <= 1'h1;
    tmr <= 4'hA;
    chipen <= 1'h1;
    repeat (3) @(posedge clk_in);
    chk("irq", 32'hE81, {20'h0, irq});
    wr(8'hB4, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'h081, {20'h0, irq});
    wr(8'h78, 32'h5);
    pins(5'h18);
    chk("pend", 32'h0, {27'h0, pend});
    wr(8'h78, 32'h8);
    pins(5'h00);
    chk("pend", 32'h10, {27'h0, pend});
    pins(5'h0F);
    chk("pend", 32'h18, {27'h0, pend});
    chk("irq", 32'h0B1, {20'h0, irq});
    pins(5'h00);
    chk("pend", 32'h1F, {27'h0, pend});
    chk("irq", 32'h0BF, {20'h0, irq});
    wr(8'h78, 32'h1);
    clr <= 5'h1F;
    @(posedge clk_in);
    clr <= 5'h00;
    pins(5'h08);
    chk("pend", 32'h0, {27'h0, pend});
    wr(8'hD0, 32'h0);
    rd(8'hD0, 32'h0, 1'h0);
    fire <= 1'h1;
    @(posedge clk_in);
    fire <= 1'h0;
    repeat (3) @(posedge clk_in);
    rd(8'hD0, 32'h1, 1'h0);
    pins(5'h18);
    chk("pend", 32'h10, {27'h0, pend});
    wdt <= 1'h1;
    @(posedge clk_in);
    wdt <= 1'h0;
    rd(8'hB8, 32'h0, 1'h0);
    chk("pend", 32'h0, {27'h0, pend});
    chk("irq", 32'h0, {20'h0, irq});
    close_out();
  end
endmodule
